/* hw/cal_regs.sv */
// calendar counters and alarm set-points of the real-time clock
// assumes one cpu i/o port on ref_clk_in and a one-cycle day tick from logic on that clock
`timescale 1ns/1ps
`include "cal_params.svh"
module cal_regs (
    input  wire logic                ref_clk_in,
    input  wire logic                srst_in,
    input  wire cal_pkg::cal_io_req_t io_req_in,
    input  wire logic                dec_mode_in,
    input  wire logic                unlock_in,
    input  wire logic                day_tick_in,
    output logic               [7:0] rdata_out,
    output cal_pkg::cal_counts_t     counts_out,
    output logic               [7:0] alarm_secs_out,
    output logic               [7:0] alarm_minutes_out
);
    import cal_pkg::*;

    cal_counts_t cnt;
    cal_counts_t next_cnt;
    logic [3:0]  weekday_hi;
    logic [3:0]  next_weekday_hi;
    logic [7:0]  alarm_secs_reg;
    logic [7:0]  alarm_minutes_reg;
    logic [7:0]  next_alarm_secs;
    logic [7:0]  next_alarm_minutes;
    logic [7:0]  next_rdata;
    logic [7:0]  date_last;
    logic [7:0]  cent_last;
    logic [7:0]  yr_last;
    logic [7:0]  inc_wd;
    logic [7:0]  inc_date;
    logic [7:0]  inc_mth;
    logic [7:0]  inc_yr;
    logic [7:0]  inc_cent;
    logic        wrap_date;
    logic        wrap_mth;
    logic        wrap_yr;
    logic        count_en;

    // last day of a month; leap years follow the year's low bits
    function automatic logic [7:0] month_days(input logic dec, input logic [7:0] m,
                                               input logic [7:0] y);
        logic [7:0] mb;
        logic [7:0] yb;
        logic [7:0] d;
        mb = dec ? 8'(m[7:4] * 4'hA + m[3:0]) : m;
        yb = dec ? 8'(y[7:4] * 4'hA + y[3:0]) : y;
        case (mb)
            8'h04, 8'h06, 8'h09, 8'h0B: d = 8'h1E;
            8'h02:                      d = (yb[1:0] == 2'b00) ? 8'h1D : 8'h1C;
            default:                    d = 8'h1F;
        endcase
        month_days = dec ? {4'(d / 8'h0A), 4'(d % 8'h0A)} : d;
    endfunction

    // counting runs only while locked
    assign count_en  = !unlock_in && day_tick_in;
    assign date_last = month_days(dec_mode_in, cnt.mth, cnt.year);
    assign yr_last   = dec_mode_in ? `CAL_CENT_LAST_DEC : `CAL_CENT_LAST_BIN;
    assign cent_last = dec_mode_in ? `CAL_CENT_LAST_DEC : `CAL_CENT_LAST_BIN;

    // one incrementer per field; weekday 1..7 is the same in either mode
    cal_digit_inc u_wd (.dec_mode_in(1'b0), .value_in(cnt.weekday),
        .first_in(`CAL_WEEKDAY_FIRST), .last_in(`CAL_WEEKDAY_LAST),
        .value_out(inc_wd), .wrap_out());
    cal_digit_inc u_date (.dec_mode_in(dec_mode_in), .value_in(cnt.date),
        .first_in(`CAL_DATE_FIRST), .last_in(date_last),
        .value_out(inc_date), .wrap_out(wrap_date));
    cal_digit_inc u_mth (.dec_mode_in(dec_mode_in), .value_in(cnt.mth),
        .first_in(`CAL_MTH_FIRST),
        .last_in(dec_mode_in ? `CAL_MTH_LAST_DEC : `CAL_MTH_LAST_BIN),
        .value_out(inc_mth), .wrap_out(wrap_mth));
    cal_digit_inc u_yr (.dec_mode_in(dec_mode_in), .value_in(cnt.year),
        .first_in(8'h00), .last_in(yr_last),
        .value_out(inc_yr), .wrap_out(wrap_yr));
    cal_digit_inc u_cent (.dec_mode_in(dec_mode_in), .value_in(cnt.hundred),
        .first_in(8'h00), .last_in(cent_last),
        .value_out(inc_cent), .wrap_out());

    // count chain and cpu writes; a write while unlocked never races a tick
    always_comb begin
        next_cnt           = cnt;
        next_weekday_hi    = weekday_hi;
        next_alarm_secs    = alarm_secs_reg;
        next_alarm_minutes = alarm_minutes_reg;
        if (count_en) begin
            next_cnt.weekday = inc_wd;
            next_cnt.date    = inc_date;
            if (wrap_date) begin
                next_cnt.mth = inc_mth;
                if (wrap_mth) begin
                    next_cnt.year = inc_yr;
                    if (wrap_yr) begin
                        next_cnt.hundred = inc_cent;
                    end
                end
            end
        end
        if (io_req_in.wr && unlock_in) begin
            case (io_req_in.addr)
                `CAL_ADDR_WEEKDAY: next_cnt.weekday = {4'h0, io_req_in.wdata[3:0]};
                `CAL_ADDR_DATE:    next_cnt.date    = io_req_in.wdata;
                `CAL_ADDR_MTH:     next_cnt.mth     = io_req_in.wdata;
                `CAL_ADDR_YEAR:    next_cnt.year    = io_req_in.wdata;
                `CAL_ADDR_HUNDRED: next_cnt.hundred = io_req_in.wdata;
                default: ;
            endcase
        end
        if (io_req_in.wr) begin
            case (io_req_in.addr)
                `CAL_ADDR_ALM_SECS: next_alarm_secs    = io_req_in.wdata;
                `CAL_ADDR_ALM_MINS: next_alarm_minutes = io_req_in.wdata;
                default: ;
            endcase
        end
        if (srst_in) begin
            next_weekday_hi = `CAL_WEEKDAY_HI_RST;
        end
    end

    // counts and set-points are not reset; only the read-only nibble is
    always_ff @(posedge ref_clk_in) begin
        cnt               <= next_cnt;
        weekday_hi        <= next_weekday_hi;
        alarm_secs_reg    <= next_alarm_secs;
        alarm_minutes_reg <= next_alarm_minutes;
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = rdata_out;
        if (io_req_in.rd) begin
            case (io_req_in.addr)
                `CAL_ADDR_WEEKDAY:  next_rdata = {weekday_hi, cnt.weekday[3:0]};
                `CAL_ADDR_DATE:     next_rdata = cnt.date;
                `CAL_ADDR_MTH:      next_rdata = cnt.mth;
                `CAL_ADDR_YEAR:     next_rdata = cnt.year;
                `CAL_ADDR_HUNDRED:  next_rdata = cnt.hundred;
                `CAL_ADDR_ALM_SECS: next_rdata = alarm_secs_reg;
                `CAL_ADDR_ALM_MINS: next_rdata = alarm_minutes_reg;
                default:            next_rdata = 8'h00;
            endcase
        end
        if (srst_in) begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        rdata_out <= next_rdata;
    end

    assign counts_out        = cnt;
    assign alarm_secs_out    = alarm_secs_reg;
    assign alarm_minutes_out = alarm_minutes_reg;

    // checks
    a_locked_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (!unlock_in && !day_tick_in) |=> $stable(counts_out))
        else $error("count changed while locked without tick");
    a_unlocked_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (unlock_in && !io_req_in.wr) |=> $stable(counts_out))
        else $error("count moved while unlocked");
    a_weekday_wrap: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (count_en && cnt.weekday == 8'h07) |=> (cnt.weekday == 8'h01))
        else $error("weekday did not wrap to one");
    a_weekday_hi: assert property (@(posedge ref_clk_in)
        srst_in |=> (weekday_hi == 4'h0))
        else $error("weekday upper nibble not cleared");
    a_alarm_write: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (io_req_in.wr && io_req_in.addr == 8'hE8) |=> (alarm_secs_out == $past(io_req_in.wdata)))
        else $error("alarm seconds write lost");
    a_cent_carry: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (count_en && wrap_date && wrap_mth && wrap_yr && !(unlock_in))
        |=> (cnt.year == 8'h00 && cnt.hundred != $past(cnt.hundred)))
        else $error("century carry missed");
    a_mth_wrap: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (count_en && wrap_date && wrap_mth) |=> (cnt.mth == 8'h01 && cnt.date == 8'h01))
        else $error("month did not wrap to one");
    a_date_step: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (count_en && !wrap_date && !dec_mode_in) |=> (cnt.date == $past(cnt.date) + 8'h01))
        else $error("binary date step wrong");
    // decimal ones digit at nine must carry into the tens, not run into a-f
    sequence s_dec_date_carry;
        count_en && dec_mode_in && !wrap_date && cnt.date[3:0] == 4'h9;
    endsequence
    a_date_dec_carry: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        s_dec_date_carry |=> (cnt.date == {$past(cnt.date[7:4]) + 4'h1, 4'h0}))
        else $error("decimal date carry wrong");
endmodule

/* include/cal_params.svh */
// register offsets, field ranges and reset values for the calendar block
// assumes inclusion by the design modules and the bench by bare name
`ifndef CAL_PARAMS_SVH
`define CAL_PARAMS_SVH
`define CAL_ADDR_WEEKDAY    8'hE3
`define CAL_ADDR_DATE       8'hE4
`define CAL_ADDR_MTH        8'hE5
`define CAL_ADDR_YEAR       8'hE6
`define CAL_ADDR_HUNDRED    8'hE7
`define CAL_ADDR_ALM_SECS   8'hE8
`define CAL_ADDR_ALM_MINS   8'hE9
`define CAL_WEEKDAY_FIRST   8'h01
`define CAL_WEEKDAY_LAST    8'h07
`define CAL_DATE_FIRST      8'h01
`define CAL_MTH_FIRST       8'h01
`define CAL_MTH_LAST_BIN    8'h0C
`define CAL_MTH_LAST_DEC    8'h12
`define CAL_CENT_LAST_BIN   8'h63
`define CAL_CENT_LAST_DEC   8'h99
`define CAL_WEEKDAY_HI_RST  4'h0
`define CAL_LOCK_RST        1'b0
`endif

/* include/cal_pkg.sv */
// shared types of the calendar and alarm register block
// assumes cal_params.svh on the include path
package cal_pkg;
    // one cpu i/o access, sampled on the block clock
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cal_io_req_t;

    // the five calendar count fields
    typedef struct packed {
        logic [7:0] weekday;
        logic [7:0] date;
        logic [7:0] mth;
        logic [7:0] year;
        logic [7:0] hundred;
    } cal_counts_t;
endpackage

/* hw/cal_digit_inc.sv */
// wrapping increment of one two-digit field, in binary or packed decimal
// assumes the caller presents an in-range value
`timescale 1ns/1ps
`include "cal_params.svh"
module cal_digit_inc (
    input  wire logic       dec_mode_in,
    input  wire logic [7:0] value_in,
    input  wire logic [7:0] first_in,
    input  wire logic [7:0] last_in,
    output logic      [7:0] value_out,
    output logic            wrap_out
);
    // decimal steps carry the ones digit into the tens at nine
    always_comb begin
        wrap_out  = (value_in == last_in);
        value_out = value_in + 8'h01;
        if (wrap_out) begin
            value_out = first_in;
        end else if (dec_mode_in && value_in[3:0] == 4'h9) begin
            value_out = {value_in[7:4] + 4'h1, 4'h0};
        end
    end
endmodule

/* tb/cal_cpu_model.sv */
// cpu side of the calendar block: one i/o access per call
// assumes the block takes a request at one rising edge and registers its answer at that same edge
`timescale 1ns/1ps
module cal_cpu_model (
    input  wire logic          clk_in,
    input  wire logic    [7:0] rdata_in,
    output cal_pkg::cal_io_req_t req_out
);
    import cal_pkg::*;

    initial begin
        req_out = '0;
    end

    // request stands for exactly one edge; address and data then turn over
    // so that a design looking at stale bus values sees garbage, not a match
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk_in);
        req_out <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk_in);
        req_out <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        @(negedge clk_in);
        q = rdata_in;
    endtask
endmodule

/* tb/cal_regs_test.sv */
// self-checking bench of the calendar and alarm registers
// assumes the cpu model drives the i/o port and the bench owns mode, lock and tick
`timescale 1ns/1ps
`include "cal_params.svh"
module cal_regs_test;
    import cal_pkg::*;
    logic        ref_clk_in;
    logic        srst_in;
    logic        dec_mode_in;
    logic        unlock_in;
    logic        day_tick_in;
    cal_io_req_t io_req;
    cal_counts_t counts;
    logic [7:0]  rdata;
    logic [7:0]  alarm_secs_value;
    logic [7:0]  amin;
    logic [7:0]  q;
    int unsigned seed = 27;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          bcd, wd, d, m, y, c, v;

    cal_cpu_model cpu (.clk_in(ref_clk_in), .rdata_in(rdata), .req_out(io_req));
    cal_regs DUT (
        .ref_clk_in        (ref_clk_in),
        .srst_in           (srst_in),
        .io_req_in         (io_req),
        .dec_mode_in       (dec_mode_in),
        .unlock_in         (unlock_in),
        .day_tick_in       (day_tick_in),
        .rdata_out         (rdata),
        .counts_out        (counts),
        .alarm_secs_out    (alarm_secs_value),
        .alarm_minutes_out (amin)
    );

    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed & 32'h7FFF_FFFF);
    endfunction
    // natural value to register encoding of the current mode
    function automatic logic [7:0] enc(int x);
        return bcd ? 8'((x / 10) * 16 + x % 10) : 8'(x);
    endfunction
    function automatic int dim();
        if (m == 2) return (y % 4 == 0) ? 29 : 28;
        return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
    endfunction
    // reference day step with all carries
    task automatic step();
        wd = (wd == 7) ? 1 : wd + 1;
        if (d < dim()) d++;
        else begin
            d = 1;
            if (m < 12) m++;
            else begin
                m = 1;
                y = (y == 99) ? 0 : y + 1;
                if (y == 0) c = (c == 99) ? 0 : c + 1;
            end
        end
    endtask
    task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        cpu.access(1'b0, a, 8'h00, q);
        cmp("rdata", e, q);
    endtask
    task automatic check_counts();
        logic [7:0] e [5];
        e = '{enc(wd), enc(d), enc(m), enc(y), enc(c)};
        for (int i = 0; i < 5; i++) begin
            cmp("count", e[i], counts[39 - 8 * i -: 8]);
            rd(8'(`CAL_ADDR_WEEKDAY + i), e[i]);
        end
    endtask
    // weekday written with a dirty high nibble, which must not stick
    task automatic load();
        @(posedge ref_clk_in);
        unlock_in <= 1'b1;
        dec_mode_in <= bcd[0];
        cpu.access(1'b1, `CAL_ADDR_WEEKDAY, 8'hF0 | enc(wd), q);
        cpu.access(1'b1, `CAL_ADDR_DATE, enc(d), q);
        cpu.access(1'b1, `CAL_ADDR_MTH, enc(m), q);
        cpu.access(1'b1, `CAL_ADDR_YEAR, enc(y), q);
        cpu.access(1'b1, `CAL_ADDR_HUNDRED, enc(c), q);
        @(posedge ref_clk_in);
        unlock_in <= 1'b0;
        // counts are looked at away from the launching edge
        @(negedge ref_clk_in);
    endtask
    // one-cycle day pulse; counting only while locked
    task automatic tick();
        @(posedge ref_clk_in);
        day_tick_in <= 1'b1;
        @(posedge ref_clk_in);
        day_tick_in <= 1'b0;
        if (!unlock_in) step();
        @(negedge ref_clk_in);
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        error_cnt++;
        give_verdict();
    end

    initial begin
        srst_in = 1'b1;
        dec_mode_in = 1'b0;
        unlock_in = 1'b0;
        day_tick_in = 1'b0;
        bcd = 0;
        repeat (3) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        // year end in both modes, century end in binary only, random month ends, then day-nine runs, both modes
        for (int k = 0; k < 8; k++) begin
            bcd = k % 2;
            m = (k < 2) ? 12 : 1 + rnd() % 12;
            y = (k < 2) ? 99 : rnd() % 100;
            c = (k < 2) ? 99 - k : rnd() % 100;
            // late runs start on day nine: plain binary step and decimal digit carry
            d = (k >= 6) ? 9 : dim();
            wd = (k == 0) ? 7 : 1 + rnd() % 7;
            load();
            check_counts();
            tick();
            check_counts();
            // locked write is ignored; alarm set points accept writes while locked
            cpu.access(1'b1, `CAL_ADDR_DATE, enc(1 + d % 28), q);
            v = rnd() % 60;
            cpu.access(1'b1, `CAL_ADDR_ALM_SECS, enc(v), q);
            cmp("alarm_secs", enc(v), alarm_secs_value);
            rd(`CAL_ADDR_ALM_SECS, enc(v));
            cpu.access(1'b1, `CAL_ADDR_ALM_MINS, enc(59 - v), q);
            rd(`CAL_ADDR_ALM_MINS, enc(59 - v));
            check_counts();
        end
        // unlocked tick does not count
        @(posedge ref_clk_in);
        unlock_in <= 1'b1;
        tick();
        check_counts();
        @(posedge ref_clk_in);
        unlock_in <= 1'b0;
        // leave non-zero read data behind so the reset clear is visible
        rd(`CAL_ADDR_WEEKDAY, enc(wd));
        // mid-run reset keeps counts and the minutes set point, clears read data
        @(posedge ref_clk_in);
        srst_in <= 1'b1;
        @(posedge ref_clk_in);
        srst_in <= 1'b0;
        @(negedge ref_clk_in);
        cmp("rdata_rst", 8'h00, rdata);
        cmp("alarm_mins", enc(59 - v), amin);
        check_counts();
        tick();
        check_counts();
        rd(8'hF0, 8'h00);
        give_verdict();
    end
endmodule
